/* hw/rgc_top.sv */
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - count shows good bytes, binary zero to eight
// - count never zero or nine-plus during error-free request in service context
// - upper 28 bits always read zero
// - count is true error-free run from the head, not threshold
// - early request by error gives smaller count
// - each data read in a service context pops one byte from a non-empty fifo
module rgc_top
	import rgc_pkg::*;
#(
	parameter int CHANNELS = 8
) (
	input  wire logic        sys_clk_in,
	input  wire logic        reset_in,
	// receiver side, one byte per push
	input  wire logic        rx_push_in,
	input  wire logic [2:0]  rx_chan_in,
	input  wire logic [7:0]  rx_byte_in,
	input  wire logic        rx_err_in,
	// service-request context
	input  wire logic        svc_active_in,
	input  wire logic [2:0]  svc_chan_in,
	output logic             good_req_out,
	output logic             exc_req_out,
	output logic             irq_out,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// channel number is three bits wide, so eight channels exactly
	if (CHANNELS != 8) begin : g_bad_channels
		$error("eight channels only");
	end
	logic [8:0]           head [CHANNELS];   // per-channel head {err,byte}
	logic [3:0]           lvl [CHANNELS];    // per-channel occupancy
	logic [CHANNELS-1:0]  pop;               // per-channel pop strobe
	logic [3:0]           good_cnt [CHANNELS]; // error-free run from head
	logic [3:0]           thr_q, thr_d;      // receive threshold
	logic [RGC_EV_W-1:0]  sts_q, sts_d;      // sticky events
	logic [RGC_EV_W-1:0]  ena_q, ena_d;      // interrupt enables
	logic                 good_q, good_d;    // previous good request level
	logic                 exc_q, exc_d;      // previous exception level
	logic [3:0]           sel_cnt;           // selected channel count
	logic [3:0]           sel_lvl;           // selected channel level
	logic [8:0]           sel_head;          // selected channel head
	logic [7:0]           sel_err;           // selected channel error flags
	logic [7:0]           errv_q [CHANNELS]; // error flags by fifo slot, head first
	logic [7:0]           errv_d [CHANNELS]; // next error flags
	logic [RGC_EV_W-1:0]  ev;                // events this cycle
	logic [7:0]           aw_q, aw_d;        // held write address
	logic                 awh_q, awh_d;      // write address held
	logic [31:0]          wd_q, wd_d;        // held write data
	logic                 wh_q, wh_d;        // write data held
	logic                 bv_q, bv_d;        // write response valid
	logic [1:0]           br_q, br_d;        // write response code
	logic                 rv_q, rv_d;        // read response valid
	logic [31:0]          rd_q, rd_d;        // read data
	logic [1:0]           rr_q, rr_d;        // read response code
	logic                 do_wr;             // write performs now
	logic                 do_rd;             // read performs now
	logic [5:0]           widx;              // write word index
	logic [5:0]           ridx;              // read word index
	logic [RGC_EV_W-1:0]  clr;               // clear bits written

	// one fifo per channel; error flag rides with each byte
	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		rgc_fifo #(.WIDTH(9), .DEPTH(8)) u_fifo (
			.sys_clk_in   (sys_clk_in),
			.reset_in     (reset_in),
			.push_in      (rx_push_in && (rx_chan_in == 3'(c))),
			.push_data_in ({rx_err_in, rx_byte_in}),
			.pop_in       (pop[c]),
			.head_out     (head[c]),
			.level_out    (lvl[c])
		);
	end

	// shadow of each fifo's error flags, kept in step with push and pop
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			errv_d[c] = pop[c] ? (errv_q[c] >> 1) : errv_q[c];
			// new byte lands behind the survivors; a full fifo refuses it
			if (rx_push_in && (rx_chan_in == 3'(c)) && (lvl[c] != RGC_CNT_MAX)) begin
				errv_d[c][3'(lvl[c] - {3'b000, pop[c]})] = rx_err_in;
			end
		end
	end

	// good count: unbroken run of error-free bytes from the head
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			good_cnt[c] = 4'h0;
			for (int i = 0; i < 8; i++) begin
				// true bytes present, no threshold clamp
				if (good_cnt[c] == 4'(i) && 4'(i) < lvl[c] && !errv_q[c][i]) begin
					good_cnt[c] = 4'(i + 1);
				end
			end
		end
	end

	// context selection uses the request channel only
	always_comb begin
		sel_cnt  = good_cnt[svc_chan_in];
		sel_lvl  = lvl[svc_chan_in];
		sel_head = head[svc_chan_in];
		sel_err  = errv_q[svc_chan_in];
	end

	// service requests: exception when head byte has an error, else error-free
	always_comb begin
		exc_d  = (sel_lvl != 4'h0) && sel_err[0];
		// at threshold, or early when an error waits behind the good run
		good_d = (sel_cnt != 4'h0) && ((sel_cnt >= thr_q) || (sel_cnt < sel_lvl));
		ev = '0;
		ev[RGC_EV_GOOD] = good_d && !good_q;
		ev[RGC_EV_EXC]  = exc_d && !exc_q;
		ev[RGC_EV_OVR]  = rx_push_in && (lvl[rx_chan_in] == RGC_CNT_MAX);
	end
	assign good_req_out = good_q;
	assign exc_req_out  = exc_q;

	// axi write/read decode
	always_comb begin
		awh_d = awh_q;
		aw_d  = aw_q;
		wh_d  = wh_q;
		wd_d  = wd_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awh_d = 1'b1;
			aw_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wh_d = 1'b1;
			wd_d = s_axi_wdata;
		end
		do_wr = awh_q && wh_q && !bv_q;
		widx  = aw_q[7:2];
		clr   = '0;
		thr_d = thr_q;
		ena_d = ena_q;
		bv_d  = bv_q && !s_axi_bready;
		br_d  = br_q;
		if (do_wr) begin
			awh_d = 1'b0;
			wh_d  = 1'b0;
			bv_d  = 1'b1;
			br_d  = RGC_RESP_OKAY;
			if (widx == RGC_IDX_CLEAR[5:0] && s_axi_wstrb[0]) begin
				clr = wd_q[RGC_EV_W-1:0];
			end else if (widx == RGC_IDX_ENABLE[5:0] && s_axi_wstrb[0]) begin
				ena_d = wd_q[RGC_EV_W-1:0];
			end else if (widx == RGC_IDX_THRESH[5:0] && s_axi_wstrb[0]) begin
				// zero or above eight in bits 3:0 is refused, kept at old value
				if (wd_q[3:0] != 4'h0 && wd_q[3:0] <= RGC_CNT_MAX) begin
					thr_d = wd_q[3:0];
				end
			end else if (widx != RGC_IDX_CLEAR[5:0] && widx != RGC_IDX_ENABLE[5:0]
					&& widx != RGC_IDX_THRESH[5:0]) begin
				br_d = RGC_RESP_SLVERR;
			end
		end
		// set wins over clear
		sts_d = (sts_q & ~clr) | ev;
		do_rd = s_axi_arvalid && s_axi_arready;
		ridx  = s_axi_araddr[7:2];
		rv_d  = rv_q && !s_axi_rready;
		rd_d  = rd_q;
		rr_d  = rr_q;
		pop   = '0;
		if (do_rd) begin
			rv_d = 1'b1;
			rr_d = RGC_RESP_OKAY;
			rd_d = 32'h0000_0000;
			case (ridx)
				RGC_IDX_COUNT[5:0]: begin
					// count in bits 3:0, upper bits zero
					rd_d[RGC_CNT_W-1:0] = (svc_active_in && sel_cnt <= RGC_CNT_MAX)
						? sel_cnt : RGC_CNT_RST;
				end
				RGC_IDX_STATUS[5:0]: rd_d[RGC_EV_W-1:0] = sts_q;
				RGC_IDX_ENABLE[5:0]: rd_d[RGC_EV_W-1:0] = ena_q;
				RGC_IDX_THRESH[5:0]: rd_d[3:0] = thr_q;
				RGC_IDX_DATA[5:0]: begin
					rd_d[8:0] = sel_head;
					// reading the data port pops the context channel
					pop[svc_chan_in] = svc_active_in && (sel_lvl != 4'h0);
				end
				RGC_IDX_CLEAR[5:0]: rd_d = 32'h0000_0000;
				default: rr_d = RGC_RESP_SLVERR;
			endcase
		end
	end
	assign s_axi_awready = !awh_q;
	assign s_axi_wready  = !wh_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_arready = !rv_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rr_q;
	assign irq_out       = |(sts_q & ena_q);

	// register all state
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			thr_q  <= RGC_THR_RST;
			sts_q  <= '0;
			ena_q  <= '0;
			good_q <= 1'b0;
			exc_q  <= 1'b0;
			aw_q   <= '0;
			awh_q  <= 1'b0;
			wd_q   <= '0;
			wh_q   <= 1'b0;
			bv_q   <= 1'b0;
			br_q   <= RGC_RESP_OKAY;
			rv_q   <= 1'b0;
			rd_q   <= '0;
			rr_q   <= RGC_RESP_OKAY;
			errv_q <= '{default: 8'h00};
		end else begin
			errv_q <= errv_d;
			thr_q  <= thr_d;
			sts_q  <= sts_d;
			ena_q  <= ena_d;
			good_q <= good_d;
			exc_q  <= exc_d;
			aw_q   <= aw_d;
			awh_q  <= awh_d;
			wd_q   <= wd_d;
			wh_q   <= wh_d;
			bv_q   <= bv_d;
			br_q   <= br_d;
			rv_q   <= rv_d;
			rd_q   <= rd_d;
			rr_q   <= rr_d;
		end
	end
endmodule
`default_nettype wire

/* hw/rgc_pkg.sv */
package rgc_pkg;
	// register byte offset and word indices
	localparam logic [7:0] RGC_OFF_COUNT  = 8'h1C;      // byte address, four times index
	localparam logic [7:0] RGC_IDX_COUNT  = 8'h07;      // printed offset, index
	localparam logic [7:0] RGC_IDX_STATUS = 8'h40;      // sticky event status
	localparam logic [7:0] RGC_IDX_CLEAR  = 8'h41;      // write-one-to-clear
	localparam logic [7:0] RGC_IDX_ENABLE = 8'h42;      // interrupt enable
	localparam logic [7:0] RGC_IDX_DATA   = 8'h43;      // receive data port
	localparam logic [7:0] RGC_IDX_THRESH = 8'h44;      // receive threshold
	// field layout
	localparam int         RGC_CNT_W      = 4;          // count field bits 3:0
	localparam logic [3:0] RGC_CNT_MAX    = 4'h8;       // eight bytes at most
	localparam logic [3:0] RGC_CNT_RST    = 4'h0;       // count reset value
	localparam logic [3:0] RGC_THR_RST    = 4'h1;       // threshold reset value
	localparam int         RGC_EV_W       = 3;          // status bits
	localparam int         RGC_EV_GOOD    = 0;          // error-free request raised
	localparam int         RGC_EV_EXC     = 1;          // exception request raised
	localparam int         RGC_EV_OVR     = 2;          // byte dropped on full fifo
	// axi responses
	localparam logic [1:0] RGC_RESP_OKAY  = 2'b00;
	localparam logic [1:0] RGC_RESP_SLVERR = 2'b10;
endpackage

/* hw/rgc_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
// one channel's receive fifo: data plus error flag, registered read data
module rgc_fifo
	import rgc_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk_in,
	input  wire logic             reset_in,
	input  wire logic             push_in,
	input  wire logic [WIDTH-1:0] push_data_in,
	input  wire logic             pop_in,
	output logic      [WIDTH-1:0] head_out,
	output logic      [3:0]       level_out
);
	localparam int AW = $clog2(DEPTH);
	// count field tops out at eight, so the depth is fixed
	if (DEPTH != 8) begin : g_bad_depth
		$error("depth must be 8");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];  // storage
	logic [AW-1:0]    wr_q, wr_d;     // write pointer
	logic [AW-1:0]    rd_q, rd_d;     // read pointer
	logic [3:0]       lvl_q, lvl_d;   // occupancy
	logic             do_push;        // push accepted
	logic             do_pop;         // pop accepted
	// pointer and level next values
	always_comb begin
		do_push = push_in && (lvl_q != 4'(DEPTH));
		do_pop  = pop_in && (lvl_q != 4'h0);
		wr_d    = do_push ? AW'(wr_q + 1'b1) : wr_q;
		rd_d    = do_pop ? AW'(rd_q + 1'b1) : rd_q;
		lvl_d   = 4'(lvl_q + {3'b000, do_push} - {3'b000, do_pop});
	end
	// register pointers
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			wr_q  <= '0;
			rd_q  <= '0;
			lvl_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			lvl_q <= lvl_d;
		end
	end
	// storage write and registered head
	always_ff @(posedge sys_clk_in) begin
		if (do_push) begin
			mem_q[wr_q] <= push_data_in;
		end
		if (reset_in) begin
			head_out <= '0;
		end else if (do_push && (wr_q == rd_d)) begin
			// a push into the slot about to be shown goes straight to the head
			head_out <= push_data_in;
		end else begin
			head_out <= mem_q[rd_d];
		end
	end
	assign level_out = lvl_q;
endmodule
`default_nettype wire

/* tb/rgc_rx_model.sv */
`timescale 1ns/1ns
`default_nettype none
// receiver stand-in: hands one byte to a channel fifo per call
module rgc_rx_model (
	input  wire logic       clk_in,
	output logic            push_out,
	output logic [2:0]      chan_out,
	output logic [7:0]      byte_out,
	output logic            err_out
);
	// idle lines at time zero
	initial begin
		push_out = 1'b0;
		chan_out = 3'h0;
		byte_out = 8'h00;
		err_out = 1'b0;
	end
	// one-cycle push, then stale lines are inverted so nobody leans on them
	task automatic send(input logic [2:0] c, input logic [7:0] b, input logic e);
		@(posedge clk_in);
		push_out <= 1'b1;
		chan_out <= c;
		byte_out <= b;
		err_out <= e;
		@(posedge clk_in);
		push_out <= 1'b0;
		chan_out <= ~c;
		byte_out <= ~b;
		err_out <= ~e;
	endtask
endmodule
`default_nettype wire

/* tb/rgc_top_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// watches the count read path, the read channel and the request flags
module rgc_top_monitor
	import rgc_pkg::*;
(
	input wire logic        sys_clk_in,
	input wire logic        reset_in,
	input wire logic        svc_active_in,
	input wire logic        good_req_out,
	input wire logic        exc_req_out,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	logic cnt_q, cnt_d; // accepted read targets the count
	logic svc_q, svc_d; // service context at that read
	logic gd_q, gd_d;   // error-free request at that read
	// capture the context of each accepted read address
	always_comb begin
		cnt_d = cnt_q;
		svc_d = svc_q;
		gd_d = gd_q;
		if (s_axi_arvalid && s_axi_arready) begin
			cnt_d = (s_axi_araddr == RGC_OFF_COUNT);
			svc_d = svc_active_in;
			gd_d = good_req_out;
		end
	end
	// register the context
	always_ff @(posedge sys_clk_in) begin
		cnt_q <= reset_in ? 1'b0 : cnt_d;
		svc_q <= reset_in ? 1'b0 : svc_d;
		gd_q <= reset_in ? 1'b0 : gd_d;
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	sequence s_cnt_ans;
		cnt_q && s_axi_rvalid;
	endsequence
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_cnt_upper_zero: assert property (s_cnt_ans |-> s_axi_rdata[31:4] == 28'h0)
		else $error("count upper bits not zero");
	a_cnt_legal_range: assert property (s_cnt_ans ##0 (svc_q && gd_q) |->
		s_axi_rdata[3:0] != 4'h0 && s_axi_rdata[3:0] <= RGC_CNT_MAX)
		else $error("count code out of range");
	a_cnt_idle_zero: assert property (s_cnt_ans ##0 !svc_q |-> s_axi_rdata[3:0] == 4'h0)
		else $error("count nonzero outside service");
	a_cnt_resp_okay: assert property (s_cnt_ans |-> s_axi_rresp == RGC_RESP_OKAY)
		else $error("count read not okay");
	a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while answer pending");
	a_req_exclusive: assert property (exc_req_out |-> !good_req_out)
		else $error("good and exception requests together");
endmodule
`default_nettype wire

/* tb/rgc_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// bench top: axi host tasks and one task per scenario
module rgc_top_tb_top
	import rgc_pkg::*;
;
	logic        sys_clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        svc_active_in = 1'b0;
	logic [2:0]  svc_chan_in = 3'h0;
	logic        rx_push_in, rx_err_in, good_req_out, exc_req_out, irq_out;
	logic [2:0]  rx_chan_in;
	logic [7:0]  rx_byte_in;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid;
	logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] d;
	logic [1:0]  r;
	int          n_errors = 0;
	int          n_checks = 0;
	always #5 sys_clk_in = ~sys_clk_in;
	rgc_top u_dut (.sys_clk_in, .reset_in, .rx_push_in, .rx_chan_in, .rx_byte_in,
		.rx_err_in, .svc_active_in, .svc_chan_in, .good_req_out, .exc_req_out,
		.irq_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	rgc_rx_model u_rx (.clk_in(sys_clk_in), .push_out(rx_push_in),
		.chan_out(rx_chan_in), .byte_out(rx_byte_in), .err_out(rx_err_in));
	// verdict and end of run
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// axi write of one word, waits for the response
	task automatic wr(input logic [7:0] idx, input logic [31:0] v);
		int i;
		@(posedge sys_clk_in);
		s_axi_awaddr <= {idx[5:0], 2'b00};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50 && !(s_axi_bvalid && !s_axi_awvalid); i++) begin
			@(posedge sys_clk_in);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 50) begin
			n_errors++;
			end_of_test();
		end
	endtask
	// axi read of one word into d and r
	task automatic rd(input logic [7:0] idx);
		int i;
		@(posedge sys_clk_in);
		s_axi_araddr <= {idx[5:0], 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk_in);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i == 50) begin
			n_errors++;
			end_of_test();
		end
	endtask
	// open a service context and let the request flags settle
	task automatic svc(input logic on, input logic [2:0] ch);
		@(posedge sys_clk_in);
		svc_active_in <= on;
		svc_chan_in <= ch;
		repeat (3) @(posedge sys_clk_in);
	endtask
	// reset values, threshold default and an unmapped word
	task automatic sc_reset;
		rd(RGC_IDX_COUNT); chk(d, 32'h0000_0000);
		rd(RGC_IDX_THRESH); chk(d, {28'h0, RGC_THR_RST});
		rd(8'h08); chk({30'h0, r}, {30'h0, RGC_RESP_SLVERR});
		wr(RGC_IDX_THRESH, 32'h0000_0009); chk({30'h0, r}, {30'h0, RGC_RESP_OKAY});
		rd(RGC_IDX_THRESH); chk(d, {28'h0, RGC_THR_RST});
		wr(RGC_IDX_COUNT, 32'h0000_0003); chk({30'h0, r}, {30'h0, RGC_RESP_SLVERR});
		rd(RGC_IDX_COUNT); chk(d, 32'h0000_0000);
	endtask
	// nine bytes into one fifo: eighth fills it, ninth is dropped and flagged
	task automatic sc_full;
		for (int i = 0; i < 9; i++) u_rx.send(3'h6, 8'h30 + 8'(i), 1'b0);
		rd(RGC_IDX_STATUS); chk(d & 32'h0000_0004, 32'h0000_0004);
		svc(1'b1, 3'h6);
		rd(RGC_IDX_COUNT); chk(d, 32'h0000_0008);
		wr(RGC_IDX_CLEAR, 32'h0000_0004);
		rd(RGC_IDX_STATUS); chk(d & 32'h0000_0004, 32'h0000_0000);
		svc(1'b0, 3'h0);
	endtask
	// count above threshold, channel from context, each data read pops
	task automatic sc_above;
		wr(RGC_IDX_THRESH, 32'h0000_0002);
		for (int i = 0; i < 5; i++) u_rx.send(3'h3, 8'hA0 + 8'(i), 1'b0);
		u_rx.send(3'h1, 8'h55, 1'b0);
		svc(1'b1, 3'h3);
		chk({31'h0, good_req_out}, 32'h0000_0001);
		rd(RGC_IDX_COUNT); chk(d, 32'h0000_0005);
		rd(RGC_IDX_DATA); chk(d, 32'h0000_00A0);
		rd(RGC_IDX_COUNT); chk(d, 32'h0000_0004);
		svc(1'b0, 3'h0);
	endtask
	// error byte cuts the request short; interrupt raise, mask, clear
	task automatic sc_early;
		wr(RGC_IDX_THRESH, 32'h0000_0004);
		wr(RGC_IDX_ENABLE, 32'h0000_0002);
		u_rx.send(3'h5, 8'h11, 1'b0);
		u_rx.send(3'h5, 8'h22, 1'b1);
		svc(1'b1, 3'h5);
		rd(RGC_IDX_COUNT); chk(d, 32'h0000_0001);
		rd(RGC_IDX_DATA); chk(d, 32'h0000_0011);
		repeat (3) @(posedge sys_clk_in);
		chk({31'h0, exc_req_out}, 32'h0000_0001);
		chk({31'h0, irq_out}, 32'h0000_0001);
		wr(RGC_IDX_ENABLE, 32'h0000_0000);
		chk({31'h0, irq_out}, 32'h0000_0000);
		rd(RGC_IDX_DATA); chk(d, 32'h0000_0122);
		wr(RGC_IDX_CLEAR, 32'h0000_0002);
		rd(RGC_IDX_STATUS); chk(d & 32'h0000_0002, 32'h0000_0000);
		svc(1'b0, 3'h0);
	endtask
	initial begin
		repeat (4) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		sc_reset();
		sc_above();
		sc_early();
		sc_full();
		end_of_test();
	end
endmodule
bind rgc_top rgc_top_monitor u_mon (.sys_clk_in, .reset_in, .svc_active_in,
	.good_req_out, .exc_req_out, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
